/* File: inc/epv_pkg.sv */
// Function
// - Lock bits have no read-back path
// - No locks: no protection, verify still keyed
// - Level one: block table reads, latch, programming
// - Level two adds verify read-back disable
// - Level three adds external execution block
// - 64-byte key array, erased to ones
// - Verify returns code XNOR selected key byte
// - Erase clears code, key and locks
// - Erased cells read as ones
// - Signature bytes at three fixed locations
// - Verify data valid quickly, released on enable high
package epv_pkg;
	// ====================
	// Timing
	localparam int CLK_MHZ = 200; // System clock rate
	localparam int TICK_US = 1; // Width measurement grain
	localparam int TICK_CYC = CLK_MHZ * TICK_US; // Cycles per tick
	localparam int PULSE_MIN_US = 90; // Shortest legal strobe
	localparam int PULSE_MAX_US = 110; // Longest legal strobe
	localparam logic [7:0] PULSE_MIN_TK = 8'(PULSE_MIN_US / TICK_US); // Round up not needed, exact
	localparam logic [7:0] PULSE_MAX_TK = 8'(PULSE_MAX_US / TICK_US); // Longest, rounded down
	localparam logic [7:0] PULSES_CODE = 8'h05; // Strobes per code byte
	localparam logic [7:0] PULSES_OTHER = 8'h19; // Strobes per key byte or lock bit
	// ====================
	// Arrays and signature
	localparam int KEY_IDX_W = 6; // 64 key bytes
	localparam logic [7:0] ERASED_BYTE = 8'hff; // Erased cell value
	localparam logic [7:0] SIG_LOC0 = 8'h30; // Signature locations
	localparam logic [7:0] SIG_LOC1 = 8'h31;
	localparam logic [7:0] SIG_LOC2 = 8'h60;
	// ====================
	// Mode pin codes, order {p26,p27,p33,p36,p37}
	localparam logic [4:0] MODE_PROG_CODE = 5'h0f;
	localparam logic [4:0] MODE_PROG_KEY = 5'h0d;
	localparam logic [4:0] MODE_LOCK1 = 5'h1f;
	localparam logic [4:0] MODE_LOCK2 = 5'h1c;
	localparam logic [4:0] MODE_LOCK3 = 5'h16;
	localparam logic [4:0] MODE_VERIFY = 5'h03;
	localparam logic [4:0] MODE_SIG = 5'h00;
	// ====================
	// Register map
	localparam int AXI_AW = 4; // Byte address width
	localparam logic [3:0] REG_CTRL = 4'h0; // Control
	localparam logic [3:0] REG_STAT = 4'h4; // Status
	localparam logic [3:0] REG_WIDTH = 4'h8; // Last strobe width
	localparam int CTRL_ERASE_BIT = 0; // Write 1 starts erase
	localparam int CTRL_CHK_BIT = 1; // Width check enable
	localparam int STAT_BUSY_BIT = 0; // Erase running
	localparam int STAT_ERR_BIT = 1; // Width error, write 1 clears
	localparam int STAT_DONE_BIT = 2; // Location got its strobes
	localparam int STAT_CNT_LSB = 8; // Strobe count field
	localparam logic CTRL_CHK_RST = 1'h0; // Check off after reset
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ====================
	// Types
	typedef struct packed {
		logic p26; // Mode pin
		logic p27; // Mode pin, verify enable when low
		logic p33;
		logic p36;
		logic p37;
	} epv_mode_pins_t;
	typedef enum logic [1:0] {
		ST_RUN = 2'b01, // Normal access
		ST_ERASE = 2'b10 // Sweep writing ones
	} epv_fsm_t;
endpackage

/* File: core/epv_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module epv_mem #(
	parameter int W = 8, // Word width
	parameter int AW = 13 // Address width
) (
	input wire logic clk_i, // Clock
	input wire logic we_i, // Write enable
	input wire logic [AW-1:0] waddr_i, // Write address
	input wire logic [W-1:0] wdata_i, // Write data
	input wire logic [AW-1:0] raddr_i, // Read address
	output logic [W-1:0] rdata_o // Registered read data
);
	// ==========================================
	// Storage, no reset: contents set by erase sweep
	logic [W-1:0] mem [2**AW]; // Cells
	generate
		if (W < 1 || AW < 1) begin : g_chk
			$error("epv_mem bad size");
		end
	endgenerate
	// Write port and registered read
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
		rdata_o <= mem[raddr_i];
	end
endmodule
`default_nettype wire

/* File: core/epv_tick.sv */
`timescale 1ns/1ps
`default_nettype none
module epv_tick #(
	parameter int DIV = 200 // Cycles per tick
) (
	input wire logic clk_i, // Clock
	input wire logic rst_i, // Sync reset, high
	output logic tick_o // One-cycle enable
);
	// ==========================================
	// Divider state
	typedef struct packed {
		logic [15:0] cnt; // Down counter
		logic tick; // Output pulse
	} epv_tick_st_t;
	epv_tick_st_t st_ff, nxt_st;
	generate
		if (DIV < 2 || DIV > 65535) begin : g_chk
			$error("epv_tick bad divider");
		end
	endgenerate
	// Count down, pulse at zero
	always_comb begin
		nxt_st = st_ff;
		nxt_st.tick = 1'b0;
		if (st_ff.cnt == 16'h0000) begin
			nxt_st.cnt = 16'(DIV - 1);
			nxt_st.tick = 1'b1;
		end else begin
			nxt_st.cnt = st_ff.cnt - 16'h0001;
		end
	end
	// Register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
	assign tick_o = st_ff.tick;
endmodule
`default_nettype wire

/* File: core/epv_port.sv */
`timescale 1ns/1ps
`default_nettype none
module epv_port
	import epv_pkg::*;
#(
	parameter int ADDR_W = 13, // Port 1 plus five port 2 lines
	parameter logic [7:0] SIG_BYTE0 = 8'h5a, // Arbitrary value
	parameter logic [7:0] SIG_BYTE1 = 8'ha5, // Arbitrary value
	parameter logic [7:0] SIG_BYTE2 = 8'h3c // Arbitrary value
) (
	input wire logic SYS_CLK_I, // 200 MHz clock
	input wire logic SYS_RST_I, // Sync reset, high
	input wire logic [ADDR_W-1:0] PROG_ADDR_I, // Location address
	input wire logic [7:0] PROG_DATA_I, // Code byte in
	output logic [7:0] PROG_DATA_O, // Verify byte out
	output logic PROG_DATA_OE_O, // Verify drive enable
	input wire logic PROGRAM_STROBE_I, // Program strobe, low pulses
	input wire logic PROGRAM_FETCH_STROBE_I, // Held low in program modes
	input wire logic PROG_RST_I, // Reset pin level, high in modes
	input wire logic PROGRAM_VOLTAGE_I, // High voltage present
	input wire logic EXTERNAL_ACCESS_SELECT_I, // External access level
	input wire epv_mode_pins_t MODE_PINS_I, // Mode select pins
	output logic CODE_TABLE_READ_BLOCK_O, // Table reads from outside blocked
	output logic EXTERNAL_ACCESS_SELECT_O, // Effective external access
	output logic EXT_EXEC_BLOCK_O, // External execution blocked
	input wire logic [AXI_AW-1:0] S_AXI_AWADDR, // Write address
	input wire logic S_AXI_AWVALID, // Write address valid
	output logic S_AXI_AWREADY, // Write address ready
	input wire logic [31:0] S_AXI_WDATA, // Write data
	input wire logic [3:0] S_AXI_WSTRB, // Byte enables
	input wire logic S_AXI_WVALID, // Write data valid
	output logic S_AXI_WREADY, // Write data ready
	output logic [1:0] S_AXI_BRESP, // Write response
	output logic S_AXI_BVALID, // Response valid
	input wire logic S_AXI_BREADY, // Response ready
	input wire logic [AXI_AW-1:0] S_AXI_ARADDR, // Read address
	input wire logic S_AXI_ARVALID, // Read address valid
	output logic S_AXI_ARREADY, // Read address ready
	output logic [31:0] S_AXI_RDATA, // Read data
	output logic [1:0] S_AXI_RRESP, // Read response
	output logic S_AXI_RVALID, // Read valid
	input wire logic S_AXI_RREADY // Read ready
);
	// ==========================================
	// State
	typedef struct packed {
		epv_fsm_t fsm; // Run or erase
		logic [ADDR_W-1:0] ptr; // Erase sweep pointer
		logic boot; // First cycle after reset
		logic ext_latch; // External access caught at reset
		logic ext_out; // Effective external access
		logic [2:0] lock; // Lock cells, never readable
		logic tbl_blk; // Table read block
		logic exe_blk; // External execution block
		logic strobe_d; // Strobe of last cycle
		logic [ADDR_W-1:0] addr_d; // Address of last cycle
		logic [4:0] mode_d; // Mode of last cycle
		logic [7:0] pcount; // Strobes on this location
		logic [7:0] wcount; // Ticks of current low pulse
		logic [7:0] wlast; // Width of last pulse
		logic err; // Width out of range, sticky
		logic chk; // Width check enable
		logic [7:0] dout; // Verify byte
		logic doe; // Verify drive
		logic awready; // Bus handshake flops
		logic wready;
		logic aw_got;
		logic w_got;
		logic [AXI_AW-1:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} epv_state_t;
	epv_state_t st_ff, nxt_st;
	localparam logic [ADDR_W-1:0] LAST_LOC = '1; // End of sweep
	generate
		if (ADDR_W < 7 || ADDR_W > 16) begin : g_chk
			$error("epv_port address width unsupported");
		end
	endgenerate
	// ==========================================
	// Memories and divider
	logic code_we; // Code write strobe
	logic [ADDR_W-1:0] code_waddr;
	logic [7:0] code_wdata;
	logic [7:0] code_rdata;
	logic key_we; // Key write strobe
	logic [KEY_IDX_W-1:0] key_waddr;
	logic [7:0] key_wdata;
	logic [7:0] key_rdata;
	logic tick; // Width grain enable
	epv_mem #(.W(8), .AW(ADDR_W)) u_code (
		.clk_i(SYS_CLK_I),
		.we_i(code_we),
		.waddr_i(code_waddr),
		.wdata_i(code_wdata),
		.raddr_i(PROG_ADDR_I),
		.rdata_o(code_rdata)
	);
	epv_mem #(.W(8), .AW(KEY_IDX_W)) u_key (
		.clk_i(SYS_CLK_I),
		.we_i(key_we),
		.waddr_i(key_waddr),
		.wdata_i(key_wdata),
		.raddr_i(PROG_ADDR_I[KEY_IDX_W-1:0]),
		.rdata_o(key_rdata)
	);
	epv_tick #(.DIV(TICK_CYC)) u_tick (
		.clk_i(SYS_CLK_I),
		.rst_i(SYS_RST_I),
		.tick_o(tick)
	);
	// ==========================================
	// Next state
	always_comb begin
		logic [4:0] mode; // Mode pins as a code
		logic run; // Pins in a program mode, not erasing
		logic fall; // Strobe went low
		logic rise; // Strobe went high
		logic burn; // Programming pulse accepted
		logic lvl1; // Protection levels
		logic lvl2;
		logic lvl3;
		logic [7:0] sig; // Signature byte for address
		logic [7:0] target; // Strobes wanted for this mode
		logic bad; // Width error found this cycle
		mode = MODE_PINS_I;
		sig = ERASED_BYTE;
		bad = 1'b0;
		nxt_st = st_ff;
		code_we = 1'b0;
		code_waddr = PROG_ADDR_I;
		code_wdata = code_rdata & PROG_DATA_I; // Cells only go from one to zero
		key_we = 1'b0;
		key_waddr = PROG_ADDR_I[KEY_IDX_W-1:0];
		key_wdata = key_rdata & PROG_DATA_I;
		run = PROG_RST_I & ~PROGRAM_FETCH_STROBE_I & (st_ff.fsm == ST_RUN);
		fall = st_ff.strobe_d & ~PROGRAM_STROBE_I;
		rise = ~st_ff.strobe_d & PROGRAM_STROBE_I;
		burn = fall & run & PROGRAM_VOLTAGE_I;
		// Levels are cumulative; other patterns are not defined
		lvl1 = st_ff.lock[0];
		lvl2 = st_ff.lock[0] & st_ff.lock[1];
		lvl3 = lvl2 & st_ff.lock[2];
		target = (mode == MODE_PROG_CODE) ? PULSES_CODE : PULSES_OTHER;
		nxt_st.strobe_d = PROGRAM_STROBE_I;
		nxt_st.addr_d = PROG_ADDR_I;
		nxt_st.mode_d = mode;
		// Erase sweep writes ones everywhere and clears locks
		case (st_ff.fsm)
			ST_ERASE: begin
				code_we = 1'b1;
				code_waddr = st_ff.ptr;
				code_wdata = ERASED_BYTE;
				key_we = 1'b1;
				key_waddr = st_ff.ptr[KEY_IDX_W-1:0];
				key_wdata = ERASED_BYTE;
				nxt_st.lock = 3'h0;
				nxt_st.ptr = st_ff.ptr + 1'b1;
				if (st_ff.ptr == LAST_LOC) begin
					nxt_st.fsm = ST_RUN;
				end
			end
			ST_RUN: begin
				// Data read last cycle is stable: address held long before the strobe
				if (burn) begin
					case (mode)
						MODE_PROG_CODE: begin
							code_we = ~lvl1;
						end
						MODE_PROG_KEY: begin
							key_we = ~lvl1;
						end
						MODE_LOCK1: begin
							nxt_st.lock[0] = 1'b1;
						end
						MODE_LOCK2: begin
							nxt_st.lock[1] = 1'b1;
						end
						MODE_LOCK3: begin
							nxt_st.lock[2] = 1'b1;
						end
						default: begin
							// Not a program mode
						end
					endcase
				end
			end
			default: begin
				nxt_st.fsm = ST_RUN;
			end
		endcase
		// Strobe count, restarted on new address or mode
		if (PROG_ADDR_I != st_ff.addr_d || mode != st_ff.mode_d) begin
			nxt_st.pcount = 8'h00;
		end else if (burn && st_ff.pcount != 8'hff) begin
			nxt_st.pcount = st_ff.pcount + 8'h01;
		end
		// Low pulse width in ticks, checked at the rising edge
		if (fall) begin
			nxt_st.wcount = 8'h00;
		end else if (~PROGRAM_STROBE_I && tick && st_ff.wcount != 8'hff) begin
			nxt_st.wcount = st_ff.wcount + 8'h01;
		end
		if (rise && run && PROGRAM_VOLTAGE_I) begin
			nxt_st.wlast = st_ff.wcount;
			if (st_ff.chk && (st_ff.wcount < PULSE_MIN_TK || st_ff.wcount > PULSE_MAX_TK)) begin
				nxt_st.err = 1'b1;
				bad = 1'b1;
			end
		end
		// Signature lookup; other addresses read as erased
		if (PROG_ADDR_I == ADDR_W'(SIG_LOC0)) begin
			sig = SIG_BYTE0;
		end else if (PROG_ADDR_I == ADDR_W'(SIG_LOC1)) begin
			sig = SIG_BYTE1;
		end else if (PROG_ADDR_I == ADDR_W'(SIG_LOC2)) begin
			sig = SIG_BYTE2;
		end
		// Verify drive: enable low, strobe high, no high voltage
		nxt_st.doe = run & PROGRAM_STROBE_I & ~PROGRAM_VOLTAGE_I & ~MODE_PINS_I.p27 &
			((mode == MODE_SIG) | ((mode == MODE_VERIFY) & ~lvl2));
		if (mode == MODE_SIG) begin
			nxt_st.dout = sig;
		end else begin
			nxt_st.dout = ~(code_rdata ^ key_rdata);
		end
		// Protection outputs, the only way lock state shows
		if (st_ff.boot) begin
			nxt_st.boot = 1'b0;
			nxt_st.ext_latch = EXTERNAL_ACCESS_SELECT_I;
		end
		nxt_st.ext_out = lvl1 ? st_ff.ext_latch : EXTERNAL_ACCESS_SELECT_I;
		nxt_st.tbl_blk = lvl1;
		nxt_st.exe_blk = lvl3;
		// ==========================================
		// Bus write channel, address and data in either order
		if (S_AXI_AWVALID && st_ff.awready) begin
			nxt_st.aw_got = 1'b1;
			nxt_st.awaddr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && st_ff.wready) begin
			nxt_st.w_got = 1'b1;
			nxt_st.wdata = S_AXI_WDATA;
			nxt_st.wstrb = S_AXI_WSTRB;
		end
		if (st_ff.bvalid && S_AXI_BREADY) begin
			nxt_st.bvalid = 1'b0;
		end
		if (nxt_st.aw_got && nxt_st.w_got && !st_ff.bvalid) begin
			nxt_st.aw_got = 1'b0;
			nxt_st.w_got = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = RESP_OKAY;
			case (nxt_st.awaddr)
				REG_CTRL: begin
					if (nxt_st.wstrb[0]) begin
						nxt_st.chk = nxt_st.wdata[CTRL_CHK_BIT];
						if (nxt_st.wdata[CTRL_ERASE_BIT] && st_ff.fsm == ST_RUN) begin
							nxt_st.fsm = ST_ERASE;
							nxt_st.ptr = '0;
						end
					end
				end
				REG_STAT: begin
					// New error in the same cycle wins over the clear
					if (nxt_st.wstrb[0] && nxt_st.wdata[STAT_ERR_BIT] && !bad) begin
						nxt_st.err = 1'b0;
					end
				end
				REG_WIDTH: begin
					// Read only
				end
				default: begin
					nxt_st.bresp = RESP_SLVERR;
				end
			endcase
		end
		nxt_st.awready = ~nxt_st.aw_got & ~nxt_st.bvalid;
		nxt_st.wready = ~nxt_st.w_got & ~nxt_st.bvalid;
		// Bus read channel
		if (st_ff.rvalid && S_AXI_RREADY) begin
			nxt_st.rvalid = 1'b0;
		end
		if (S_AXI_ARVALID && st_ff.arready) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rresp = RESP_OKAY;
			nxt_st.rdata = 32'h0000_0000;
			case (S_AXI_ARADDR)
				REG_CTRL: begin
					nxt_st.rdata[CTRL_CHK_BIT] = st_ff.chk;
				end
				REG_STAT: begin
					nxt_st.rdata[STAT_BUSY_BIT] = (st_ff.fsm == ST_ERASE);
					nxt_st.rdata[STAT_ERR_BIT] = st_ff.err;
					nxt_st.rdata[STAT_DONE_BIT] = (st_ff.pcount >= target);
					nxt_st.rdata[STAT_CNT_LSB +: 8] = st_ff.pcount;
				end
				REG_WIDTH: begin
					nxt_st.rdata[7:0] = st_ff.wlast;
				end
				default: begin
					nxt_st.rresp = RESP_SLVERR;
				end
			endcase
		end
		nxt_st.arready = ~nxt_st.rvalid;
	end
	// ==========================================
	// Register; reset starts an erase so arrays are defined
	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			st_ff <= '0;
			st_ff.fsm <= ST_ERASE;
			st_ff.boot <= 1'b1;
			st_ff.strobe_d <= 1'b1;
			st_ff.chk <= CTRL_CHK_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end
	// ==========================================
	// Outputs, all straight from flops
	assign PROG_DATA_O = st_ff.dout;
	assign PROG_DATA_OE_O = st_ff.doe;
	assign CODE_TABLE_READ_BLOCK_O = st_ff.tbl_blk;
	assign EXTERNAL_ACCESS_SELECT_O = st_ff.ext_out;
	assign EXT_EXEC_BLOCK_O = st_ff.exe_blk;
	assign S_AXI_AWREADY = st_ff.awready;
	assign S_AXI_WREADY = st_ff.wready;
	assign S_AXI_BRESP = st_ff.bresp;
	assign S_AXI_BVALID = st_ff.bvalid;
	assign S_AXI_ARREADY = st_ff.arready;
	assign S_AXI_RDATA = st_ff.rdata;
	assign S_AXI_RRESP = st_ff.rresp;
	assign S_AXI_RVALID = st_ff.rvalid;
endmodule
`default_nettype wire

/* File: bench/epv_port_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module epv_port_assertions
	import epv_pkg::*;
#(
	parameter int ADDR_W = 13, // Location address width
	parameter logic [7:0] SIG_BYTE0 = 8'h5a // First signature byte
) (
	input wire logic SYS_CLK_I, // Clock
	input wire logic SYS_RST_I, // Sync reset, high
	input wire logic [ADDR_W-1:0] PROG_ADDR_I, // Location address
	input wire logic [7:0] PROG_DATA_O, // Verify byte out
	input wire logic PROG_DATA_OE_O, // Verify drive enable
	input wire logic PROGRAM_STROBE_I, // Program strobe
	input wire logic PROGRAM_VOLTAGE_I, // High voltage present
	input wire logic EXTERNAL_ACCESS_SELECT_I, // External access level
	input wire epv_mode_pins_t MODE_PINS_I, // Mode select pins
	input wire logic CODE_TABLE_READ_BLOCK_O, // Level one active
	input wire logic EXTERNAL_ACCESS_SELECT_O, // Effective external access
	input wire logic EXT_EXEC_BLOCK_O, // Level three active
	input wire logic S_AXI_AWVALID, // Write address valid
	input wire logic S_AXI_AWREADY, // Write address ready
	input wire logic S_AXI_WVALID, // Write data valid
	input wire logic S_AXI_WREADY, // Write data ready
	input wire logic S_AXI_BVALID, // Response valid
	input wire logic S_AXI_ARVALID, // Read address valid
	input wire logic S_AXI_ARREADY, // Read address ready
	input wire logic S_AXI_RVALID // Read valid
);
	// ====================
	// One clock domain
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (SYS_RST_I);
	// ====================
	// Verify path
	AST_OE_CAUSE: assert property (PROG_DATA_OE_O |-> $past(PROGRAM_STROBE_I && !PROGRAM_VOLTAGE_I && !MODE_PINS_I.p27))
		else $error("drive without enable");
	AST_OE_RELEASE: assert property ($rose(MODE_PINS_I.p27) |=> !PROG_DATA_OE_O)
		else $error("lines not released");
	AST_OE_LOCKED: assert property (EXT_EXEC_BLOCK_O && PROG_DATA_OE_O |-> $past(MODE_PINS_I) == MODE_SIG)
		else $error("code read back while locked");
	// Eight cycles lie inside the reset sweep
	AST_ERASE_QUIET: assert property ($fell(SYS_RST_I) |-> !PROG_DATA_OE_O [*8])
		else $error("drive during erase");
	AST_SIG_FIRST: assert property (PROG_DATA_OE_O && $past(MODE_PINS_I) == MODE_SIG
		&& $past(PROG_ADDR_I) == ADDR_W'(SIG_LOC0) |-> PROG_DATA_O == SIG_BYTE0)
		else $error("signature byte wrong");
	// ====================
	// Protection levels
	AST_LEVEL_NEST: assert property (EXT_EXEC_BLOCK_O |-> CODE_TABLE_READ_BLOCK_O)
		else $error("level three without level one");
	AST_EA_HELD: assert property (CODE_TABLE_READ_BLOCK_O && $past(CODE_TABLE_READ_BLOCK_O) |-> $stable(EXTERNAL_ACCESS_SELECT_O))
		else $error("latched access moved");
	AST_EA_FOLLOW: assert property (!CODE_TABLE_READ_BLOCK_O && !$past(CODE_TABLE_READ_BLOCK_O) && !$past(SYS_RST_I)
		|-> EXTERNAL_ACCESS_SELECT_O == $past(EXTERNAL_ACCESS_SELECT_I))
		else $error("access not following pin");
	// ====================
	// Register bus answers
	AST_RD_ANSWER: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
		else $error("read answer late");
	AST_WR_ANSWER: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |=> S_AXI_BVALID)
		else $error("write answer late");
endmodule
bind epv_port epv_port_assertions #(.ADDR_W(ADDR_W), .SIG_BYTE0(SIG_BYTE0)) epv_port_assertions_inst (
	.SYS_CLK_I(SYS_CLK_I), .SYS_RST_I(SYS_RST_I), .PROG_ADDR_I(PROG_ADDR_I), .PROG_DATA_O(PROG_DATA_O),
	.PROG_DATA_OE_O(PROG_DATA_OE_O), .PROGRAM_STROBE_I(PROGRAM_STROBE_I), .PROGRAM_VOLTAGE_I(PROGRAM_VOLTAGE_I),
	.EXTERNAL_ACCESS_SELECT_I(EXTERNAL_ACCESS_SELECT_I), .MODE_PINS_I(MODE_PINS_I),
	.CODE_TABLE_READ_BLOCK_O(CODE_TABLE_READ_BLOCK_O), .EXTERNAL_ACCESS_SELECT_O(EXTERNAL_ACCESS_SELECT_O),
	.EXT_EXEC_BLOCK_O(EXT_EXEC_BLOCK_O), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
	.S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
	.S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID));
`default_nettype wire

/* File: bench/epv_prog_model.sv */
`timescale 1ns/1ps
`default_nettype none
module epv_prog_model
	import epv_pkg::*;
#(
	parameter int ADDR_W = 7, // Location address width
	parameter int HOLD = 48, // Oscillator periods around each strobe train
	parameter int GAP = 4 // Shortened high time; width check is off for these
) (
	input wire logic clk_i, // Clock
	input wire logic [7:0] bus_i, // Resolved data lines
	input wire logic bus_oe_i, // Device drives the data lines
	output logic [ADDR_W-1:0] addr_o, // Location address
	output logic [7:0] data_o, // Code byte
	output logic strobe_o, // Program strobe
	output logic vpp_o, // Programming voltage
	output var epv_mode_pins_t mode_o // Mode select pins
);
	// ====================
	// Idle levels: strobe high, no voltage, verify code selected
	initial begin
		addr_o = '0;
		data_o = 8'h00;
		strobe_o = 1'b1;
		vpp_o = 1'b0;
		mode_o = epv_mode_pins_t'(MODE_VERIFY);
	end
	// ====================
	// One location: address, data, mode, voltage, then n low pulses
	task automatic burn(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [4:0] m, input int n, input int low);
		@(posedge clk_i);
		addr_o <= a;
		data_o <= d;
		repeat (2) @(posedge clk_i);
		mode_o <= epv_mode_pins_t'(m);
		repeat (HOLD) @(posedge clk_i);
		vpp_o <= 1'b1;
		repeat (HOLD) @(posedge clk_i);
		for (int i = 0; i < n; i++) begin
			strobe_o <= 1'b0;
			repeat (low) @(posedge clk_i);
			strobe_o <= 1'b1;
			repeat (GAP) @(posedge clk_i);
		end
		repeat (HOLD) @(posedge clk_i);
		vpp_o <= 1'b0;
	endtask
	// ====================
	// Read back; released lines show the inverse of the last byte
	task automatic read_back(input logic [ADDR_W-1:0] a, input logic [4:0] m, output logic [7:0] d, output logic oe);
		@(posedge clk_i);
		vpp_o <= 1'b0;
		addr_o <= a;
		data_o <= ~data_o;
		mode_o <= epv_mode_pins_t'(m);
		repeat (HOLD) @(posedge clk_i);
		d = bus_i;
		oe = bus_oe_i;
	endtask
endmodule
`default_nettype wire

/* File: bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import epv_pkg::*;
	localparam int AW = 7; // Short erase sweep of 128 cycles
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ea = 1'b1; // Caught high at reset
	logic [3:0] awaddr = 4'h0, araddr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] rdata, q;
	logic [1:0] bresp, rresp, r;
	logic awready, wready, bvalid, arready, rvalid, dout_oe, tbl_blk, ea_eff, exec_blk, strobe, vpp;
	logic [7:0] dout, m_data, bus_d;
	logic [AW-1:0] m_addr;
	epv_mode_pins_t m_mode;
	int n_mismatch = 0;
	int compares = 0;
	always #2.5 clk = ~clk;
	// Whoever enables drives the shared data lines
	assign bus_d = dout_oe ? dout : m_data;
	epv_port #(.ADDR_W(AW)) epv_port_inst (.SYS_CLK_I(clk), .SYS_RST_I(rst), .PROG_ADDR_I(m_addr), .PROG_DATA_I(bus_d),
		.PROG_DATA_O(dout), .PROG_DATA_OE_O(dout_oe), .PROGRAM_STROBE_I(strobe), .PROGRAM_FETCH_STROBE_I(1'b0),
		.PROG_RST_I(1'b1), .PROGRAM_VOLTAGE_I(vpp), .EXTERNAL_ACCESS_SELECT_I(ea), .MODE_PINS_I(m_mode),
		.CODE_TABLE_READ_BLOCK_O(tbl_blk), .EXTERNAL_ACCESS_SELECT_O(ea_eff), .EXT_EXEC_BLOCK_O(exec_blk),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
		.S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready));
	epv_prog_model #(.ADDR_W(AW)) epv_prog_model_inst (.clk_i(clk), .bus_i(bus_d), .bus_oe_i(dout_oe),
		.addr_o(m_addr), .data_o(m_data), .strobe_o(strobe), .vpp_o(vpp), .mode_o(m_mode));
	// ====================
	// Reporting
	task automatic give_verdict();
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic overtime();
		n_mismatch++;
		$display("wrong value bus wait expected answer seen none");
		give_verdict();
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// ====================
	// One register access; each channel released at its own handshake
	task automatic axi(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic [1:0] r);
		logic fin;
		fin = 1'b0;
		q = 32'h0;
		@(posedge clk);
		if (wr) begin
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
		end else begin
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
		end
		for (int k = 0; k < 300 && !fin; k++) begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (arvalid && arready) arvalid <= 1'b0;
			if (bready && bvalid) begin
				fin = 1'b1;
				r = bresp;
				bready <= 1'b0;
			end
			if (rready && rvalid) begin
				fin = 1'b1;
				r = rresp;
				q = rdata;
				rready <= 1'b0;
			end
		end
		if (!fin) overtime();
	endtask
	// Strobe count, done and error fields of the status word
	task automatic stat(input logic [7:0] cnt, input logic done, input logic err);
		axi(1'b0, REG_STAT, 32'h0, q, r);
		chk({q[15:8], q[2:0]}, {cnt, done, err, 1'b0}, "status");
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		axi(1'b1, a, d, q, r);
		chk(r, RESP_OKAY, "write response");
	endtask
	task automatic wait_idle();
		q = 32'h1;
		for (int k = 0; k < 100 && q[0]; k++) axi(1'b0, REG_STAT, 32'h0, q, r);
		if (q[0] !== 1'b0) overtime();
	endtask
	task automatic ver(input logic [AW-1:0] a, input logic [4:0] m, input logic [7:0] e, input logic eoe);
		logic [7:0] d;
		logic oe;
		epv_prog_model_inst.read_back(a, m, d, oe);
		chk(oe, eoe, "data drive");
		if (eoe) chk(d, e, "read back byte");
	endtask
	task automatic burn(input logic [AW-1:0] a, input logic [7:0] d, input logic [4:0] m, input int n, input int low);
		epv_prog_model_inst.burn(a, d, m, n, low);
	endtask
	// ====================
	// Main sequence
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		wait_idle();
		axi(1'b0, 4'hc, 32'h0, q, r);
		chk(q, 32'h0, "unmapped data");
		chk(r, RESP_SLVERR, "unmapped response");
		axi(1'b0, REG_CTRL, 32'h0, q, r);
		chk(q[1:0], {CTRL_CHK_RST, 1'b0}, "control reset");
		ea <= 1'b0;
		repeat (3) @(posedge clk);
		chk(ea_eff, 1'b0, "external access");
		ver(7'h05, MODE_VERIFY, 8'hff, 1'b1);
		ver(7'h30, MODE_SIG, 8'h5a, 1'b1);
		ver(7'h31, MODE_SIG, 8'ha5, 1'b1);
		ver(7'h60, MODE_SIG, 8'h3c, 1'b1);
		ver(7'h32, MODE_SIG, 8'hff, 1'b1);
		$display("test erased done");
		burn(7'h05, 8'h3c, MODE_PROG_CODE, 4, 4);
		stat(8'h04, 1'b0, 1'b0);
		burn(7'h05, 8'h3c, MODE_PROG_CODE, 1, 4);
		stat(8'h05, 1'b1, 1'b0);
		ver(7'h05, MODE_VERIFY, 8'h3c, 1'b1);
		burn(7'h05, 8'h0f, MODE_PROG_KEY, 24, 4);
		stat(8'h18, 1'b0, 1'b0);
		burn(7'h05, 8'h0f, MODE_PROG_KEY, 1, 4);
		stat(8'h19, 1'b1, 1'b0);
		ver(7'h05, MODE_VERIFY, 8'hcc, 1'b1);
		ver(7'h45, MODE_VERIFY, 8'h0f, 1'b1);
		ver(7'h06, MODE_VERIFY, 8'hff, 1'b1);
		$display("test code and key done");
		wr(REG_CTRL, 32'h2);
		burn(7'h07, 8'h55, MODE_PROG_CODE, 1, 20 * TICK_CYC);
		stat(8'h01, 1'b0, 1'b1);
		axi(1'b0, REG_WIDTH, 32'h0, q, r);
		chk(q[7:0] >= 8'd19 && q[7:0] <= 8'd21, 1'b1, "strobe width");
		wr(REG_STAT, 32'h2);
		stat(8'h01, 1'b0, 1'b0);
		wr(REG_CTRL, 32'h0);
		ver(7'h07, MODE_VERIFY, 8'h55, 1'b1);
		$display("test width done");
		burn(7'h00, 8'hff, MODE_LOCK1, 25, 4);
		chk({tbl_blk, exec_blk, ea_eff}, 3'b101, "level one outputs");
		burn(7'h09, 8'h00, MODE_PROG_CODE, 5, 4);
		ver(7'h09, MODE_VERIFY, 8'hff, 1'b1);
		ver(7'h05, MODE_VERIFY, 8'hcc, 1'b1);
		burn(7'h00, 8'hff, MODE_LOCK2, 25, 4);
		ver(7'h05, MODE_VERIFY, 8'h00, 1'b0);
		ver(7'h30, MODE_SIG, 8'h5a, 1'b1);
		chk({tbl_blk, exec_blk}, 2'b10, "level two outputs");
		burn(7'h00, 8'hff, MODE_LOCK3, 25, 4);
		chk({tbl_blk, exec_blk}, 2'b11, "level three outputs");
		ver(7'h31, MODE_SIG, 8'ha5, 1'b1);
		$display("test locks done");
		wr(REG_CTRL, 32'h1);
		wait_idle();
		chk({tbl_blk, exec_blk, ea_eff}, 3'b000, "outputs after erase");
		ver(7'h05, MODE_VERIFY, 8'hff, 1'b1);
		$display("test erase done");
		give_verdict();
	end
endmodule
`default_nettype wire
